// >>> logic/pdfpc_defs.svh
// register offsets, field masks, reset values and pin positions of the port d function block
`ifndef PDFPC_DEFS_SVH
`define PDFPC_DEFS_SVH

// byte offsets of the registers inside the port window
`define PDFPC_OFS_ALT_A      8'h08
`define PDFPC_OFS_ALT_B      8'h0c
`define PDFPC_OFS_OPEN_DRAIN 8'h28
`define PDFPC_OFS_PULLUP     8'h2c
`define PDFPC_OFS_PULLDOWN   8'h30

// implemented bits of each register; everything else reads zero
`define PDFPC_MASK_ALT_A     32'h0000007f
`define PDFPC_MASK_ALT_B     32'h00000013
`define PDFPC_MASK_PIN       32'h0000007f

// reset value shared by all registers
`define PDFPC_RESET_VALUE    32'h00000000
`define PDFPC_PIN_COUNT      7

// pin positions of the alternate functions
`define PDFPC_PIN_RX         6
`define PDFPC_PIN_TX         5
`define PDFPC_PIN_SCLK       4
`define PDFPC_PIN_INT        3
`define PDFPC_PIN_ENC_Z      2
`define PDFPC_PIN_ENC_B      1
`define PDFPC_PIN_ENC_A      0

`endif

// >>> logic/pdfpc_pkg.sv
// types shared by the port d function and pad control block
`default_nettype none

package pdfpc_pkg;

	// one bit per port pin
	typedef logic [6:0] pdfpc_pins_type;

	// what a pin is currently used for
	typedef enum logic [1:0] {
		PDFPC_MODE_PORT,
		PDFPC_MODE_ALT_A,
		PDFPC_MODE_ALT_B
	} pdfpc_pin_mode_type;

	// select a wins if software sets both bits, which it must not do
	function automatic pdfpc_pin_mode_type pdfpc_pin_mode(input logic sel_a, input logic sel_b);
		pdfpc_pin_mode_type mode;
		mode = PDFPC_MODE_PORT;
		if (sel_a)
			mode = PDFPC_MODE_ALT_A;
		else if (sel_b)
			mode = PDFPC_MODE_ALT_B;
		return mode;
	endfunction

endpackage

`default_nettype wire

// >>> logic/pdfpc_pad_drive.sv
// output driver of one pad: push-pull or open-drain, with standby blocking
`timescale 1ns/10ps
`default_nettype none

module pdfpc_pad_drive (
	input  wire logic out_val_i,
	input  wire logic drive_en_i,
	input  wire logic open_drain_i,
	input  wire logic block_drive_i,
	output logic      pad_out_o,
	output logic      pad_oe_o
);

	// open-drain pulls low only; a high value releases the pad to the pull-up
	always_comb
	begin
		pad_out_o = open_drain_i ? 1'b0 : out_val_i;
		pad_oe_o  = drive_en_i & ~block_drive_i & (~open_drain_i | ~out_val_i);
	end

endmodule

`default_nettype wire

// >>> logic/pdfpc_top.sv
// port d pin function selection and pad configuration registers with pad routing
//
// Functional notes
// - select a bits route pins to first functions
// - select b implements bits four, one, zero
// - open-drain bit chooses cmos or open-drain
// - pull-up bit enables pin pull-up
// - pull-down bit enables pin pull-down
// - reset leaves every pin plain, disabled
// - selected interrupt input survives stop mode
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pdfpc_defs.svh"

module pdfpc_top (
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic [6:0]  port_data_i,
	input  wire logic [6:0]  port_out_en_i,
	input  wire logic [6:0]  pin_input_enable_i,
	input  wire logic        stop_mode_i,
	input  wire logic        standby_pin_drive_i,
	input  wire logic [6:0]  pad_in_i,
	output logic      [6:0]  pad_out_o,
	output logic      [6:0]  pad_oe_o,
	output logic      [6:0]  pullup_o,
	output logic      [6:0]  pulldown_o,
	input  wire logic        serial2_transmit_i,
	input  wire logic        serial2_clock_i,
	input  wire logic        serial2_clock_oe_i,
	input  wire logic        timer5_output_i,
	output logic             serial2_receive_o,
	output logic             serial2_clock_in_o,
	output logic             serial2_clear_to_send_o,
	output logic             external_interrupt_nine_o,
	output logic             encoder0_index_o,
	output logic             encoder0_phase_b_o,
	output logic             encoder0_phase_a_o,
	output logic             timer5_input_o,
	output logic      [6:0]  port_pin_value_o
);

	pdfpc_pkg::pdfpc_pins_type alt_select_a;      // first function selects
	pdfpc_pkg::pdfpc_pins_type alt_select_b;      // second function selects
	pdfpc_pkg::pdfpc_pins_type open_drain_select; // driver type per pin
	pdfpc_pkg::pdfpc_pins_type pullup_select;     // pull-up enables
	pdfpc_pkg::pdfpc_pins_type pulldown_select;   // pull-down enables
	logic [6:0]                next_out_val;      // value offered to each driver
	logic [6:0]                next_drive_en;     // enable offered to each driver
	wire logic [6:0]           next_pad_out;      // driver cell outputs, one cell per bit
	wire logic [6:0]           next_pad_oe;       // driver cell enables, one cell per bit
	logic [6:0]                pad_seen;          // pad levels past the input gates
	logic                      block_drive;       // stop mode with pin drive off

	// write decode, shared by every register
	function automatic logic wr_hit(input logic [7:0] ofs);
		return reg_wr_i && (reg_addr_i == ofs);
	endfunction

	// implemented bits of a write, cut to the pin width
	function automatic logic [6:0] wr_bits(input logic [31:0] mask);
		logic [31:0] v;
		v = reg_wdata_i & mask;
		return v[6:0];
	endfunction

	// function selects; both come up cleared so every pin starts as port
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			alt_select_a <= 7'(`PDFPC_RESET_VALUE);
			alt_select_b <= 7'(`PDFPC_RESET_VALUE);
		end
		else
		begin
			if (wr_hit(`PDFPC_OFS_ALT_A))
				alt_select_a <= wr_bits(`PDFPC_MASK_ALT_A);
			if (wr_hit(`PDFPC_OFS_ALT_B))
				alt_select_b <= wr_bits(`PDFPC_MASK_ALT_B);
		end
	end

	// pad configuration: driver type and pull resistors
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			open_drain_select <= 7'(`PDFPC_RESET_VALUE);
			pullup_select     <= 7'(`PDFPC_RESET_VALUE);
			pulldown_select   <= 7'(`PDFPC_RESET_VALUE);
		end
		else
		begin
			if (wr_hit(`PDFPC_OFS_OPEN_DRAIN))
				open_drain_select <= wr_bits(`PDFPC_MASK_PIN);
			if (wr_hit(`PDFPC_OFS_PULLUP))
				pullup_select <= wr_bits(`PDFPC_MASK_PIN);
			if (wr_hit(`PDFPC_OFS_PULLDOWN))
				pulldown_select <= wr_bits(`PDFPC_MASK_PIN);
		end
	end

	// read data stand for one cycle only; unmapped offsets read zero
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			reg_rdata_o <= 32'h00000000;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				`PDFPC_OFS_ALT_A:      reg_rdata_o <= {25'h0, alt_select_a};
				`PDFPC_OFS_ALT_B:      reg_rdata_o <= {25'h0, alt_select_b};
				`PDFPC_OFS_OPEN_DRAIN: reg_rdata_o <= {25'h0, open_drain_select};
				`PDFPC_OFS_PULLUP:     reg_rdata_o <= {25'h0, pullup_select};
				`PDFPC_OFS_PULLDOWN:   reg_rdata_o <= {25'h0, pulldown_select};
				default:               reg_rdata_o <= 32'h00000000;
			endcase
		end
		else
			reg_rdata_o <= 32'h00000000;
	end

	// source of each pad driver; input-only functions switch the driver off
	always_comb
	begin
		next_out_val  = port_data_i;
		next_drive_en = port_out_en_i;
		for (int i = 0; i < `PDFPC_PIN_COUNT; i++)
		begin
			// a wins over b should software break the single-select promise
			if (pdfpc_pkg::pdfpc_pin_mode(alt_select_a[i], alt_select_b[i]) != pdfpc_pkg::PDFPC_MODE_PORT)
				next_drive_en[i] = 1'b0;
		end
		if (alt_select_a[`PDFPC_PIN_TX])
		begin
			next_out_val[`PDFPC_PIN_TX]  = serial2_transmit_i;
			next_drive_en[`PDFPC_PIN_TX] = 1'b1;
		end
		if (alt_select_a[`PDFPC_PIN_SCLK])
		begin
			next_out_val[`PDFPC_PIN_SCLK]  = serial2_clock_i;
			next_drive_en[`PDFPC_PIN_SCLK] = serial2_clock_oe_i;
		end
		if (pdfpc_pkg::pdfpc_pin_mode(alt_select_a[1], alt_select_b[1]) == pdfpc_pkg::PDFPC_MODE_ALT_B)
		begin
			next_out_val[1]  = timer5_output_i;
			next_drive_en[1] = 1'b1;
		end
	end

	// pins stop driving in stop mode unless standby drive is kept on
	assign block_drive = stop_mode_i & ~standby_pin_drive_i;
	assign pad_seen    = pad_in_i & pin_input_enable_i;

	// one driver cell per pin
	for (genvar g = 0; g < `PDFPC_PIN_COUNT; g++)
	begin : drv
		pdfpc_pad_drive u_drive (
			.out_val_i     (next_out_val[g]),
			.drive_en_i    (next_drive_en[g]),
			.open_drain_i  (open_drain_select[g]),
			.block_drive_i (block_drive),
			.pad_out_o     (next_pad_out[g]),
			.pad_oe_o      (next_pad_oe[g])
		);
	end

	// pad side outputs, registered so the pads see clean levels
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			pad_out_o  <= 7'h00;
			pad_oe_o   <= 7'h00;
			pullup_o   <= 7'h00;
			pulldown_o <= 7'h00;
		end
		else
		begin
			pad_out_o  <= next_pad_out;
			pad_oe_o   <= next_pad_oe;
			pullup_o   <= pullup_select;
			pulldown_o <= pulldown_select;
		end
	end

	// peripheral inputs: each sees its pad only when selected and input enabled; the port pin values need the input enable only
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			serial2_receive_o       <= 1'b0;
			serial2_clock_in_o      <= 1'b0;
			serial2_clear_to_send_o <= 1'b0;
			encoder0_index_o        <= 1'b0;
			encoder0_phase_b_o      <= 1'b0;
			encoder0_phase_a_o      <= 1'b0;
			timer5_input_o          <= 1'b0;
			port_pin_value_o        <= 7'h00;
		end
		else
		begin
			serial2_receive_o       <= alt_select_a[`PDFPC_PIN_RX] & pad_seen[`PDFPC_PIN_RX];
			serial2_clock_in_o      <= alt_select_a[`PDFPC_PIN_SCLK] & pad_seen[`PDFPC_PIN_SCLK];
			serial2_clear_to_send_o <= pdfpc_pkg::pdfpc_pin_mode(alt_select_a[4], alt_select_b[4])
				== pdfpc_pkg::PDFPC_MODE_ALT_B && pad_seen[4];
			encoder0_index_o        <= alt_select_a[`PDFPC_PIN_ENC_Z] & pad_seen[`PDFPC_PIN_ENC_Z];
			encoder0_phase_b_o      <= alt_select_a[`PDFPC_PIN_ENC_B] & pad_seen[`PDFPC_PIN_ENC_B];
			encoder0_phase_a_o      <= alt_select_a[`PDFPC_PIN_ENC_A] & pad_seen[`PDFPC_PIN_ENC_A];
			timer5_input_o          <= pdfpc_pkg::pdfpc_pin_mode(alt_select_a[0], alt_select_b[0])
				== pdfpc_pkg::PDFPC_MODE_ALT_B && pad_seen[0];
			port_pin_value_o        <= pad_seen;
		end
	end

	// interrupt input: outside stop mode the input enable alone passes it,
	// in stop mode the function select is needed too; pin drive does not matter
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
			external_interrupt_nine_o <= 1'b0;
		else
			external_interrupt_nine_o <= pad_seen[`PDFPC_PIN_INT]
				& (~stop_mode_i | alt_select_a[`PDFPC_PIN_INT]);
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	sequence wr_alt_a_s;
		reg_wr_i && reg_addr_i == `PDFPC_OFS_ALT_A;
	endsequence

	sequence rd_alt_a_s;
		reg_rd_i && reg_addr_i == `PDFPC_OFS_ALT_A;
	endsequence

	alt_a_readback_a: assert property (wr_alt_a_s ##1 rd_alt_a_s |=> reg_rdata_o == ($past(reg_wdata_i, 2) & `PDFPC_MASK_ALT_A))
		else $error("select a read back wrong");

	alt_b_holes_a: assert property (reg_rd_i && reg_addr_i == `PDFPC_OFS_ALT_B |=> (reg_rdata_o & ~`PDFPC_MASK_ALT_B) == 32'h0)
		else $error("select b unimplemented bits not zero");

	open_drain_low_a: assert property ((pad_oe_o & pad_out_o & $past(open_drain_select)) == 7'h00)
		else $error("open-drain pin driven high");

	pullup_follow_a: assert property (reg_wr_i && reg_addr_i == `PDFPC_OFS_PULLUP |-> ##2 pullup_o == $past(reg_wdata_i[6:0], 2))
		else $error("pull-up not following write");

	pulldown_follow_a: assert property (reg_wr_i && reg_addr_i == `PDFPC_OFS_PULLDOWN |-> ##2 pulldown_o == $past(reg_wdata_i[6:0], 2))
		else $error("pull-down not following write");

	reset_state_a: assert property ($past(srst_i) |-> alt_select_a == 7'h00 && alt_select_b == 7'h00 && pad_oe_o == 7'h00 && pullup_o == 7'h00)
		else $error("pins not plain after reset");

	int_stop_a: assert property (stop_mode_i && alt_select_a[3] && pad_in_i[3] && pin_input_enable_i[3] |=> external_interrupt_nine_o)
		else $error("interrupt lost in stop mode");

	tx_route_a: assert property (alt_select_a[5] && !stop_mode_i && !open_drain_select[5] |=> pad_oe_o[5] && pad_out_o[5] == $past(serial2_transmit_i))
		else $error("transmit pin not driven by peripheral");

	both_select_a: assert property (alt_select_a[1] && alt_select_b[1] |=> !pad_oe_o[1] && !timer5_input_o)
		else $error("select a did not win");

	// with both selects clear, push-pull and no stop-mode blocking, the pin is a plain port and follows its output enable
	port_use_a: assert property (!alt_select_a[2] && !alt_select_b[2] && !block_drive && !open_drain_select[2] |=> pad_oe_o[2] == $past(port_out_en_i[2]))
		else $error("port pin not following output enable");

endmodule

`default_nettype wire

// >>> tb/pdfpc_pad_model.sv
// far-side model of the seven port d pads: pin drivers, pulls and floating lines
`timescale 1ns/10ps
`default_nettype none

module pdfpc_pad_model (
	input  wire logic       core_clk_i,
	input  wire logic [6:0] pad_out_i,
	input  wire logic [6:0] pad_oe_i,
	input  wire logic [6:0] pullup_i,
	input  wire logic [6:0] pulldown_i,
	input  wire logic [6:0] ext_val_i,
	input  wire logic [6:0] ext_en_i,
	output logic      [6:0] pad_level_o
);
	logic [6:0] float_q = 7'h55; // level of an undriven, unpulled pin

	// a loose pin wanders every cycle so a stale value is never trusted
	always @(posedge core_clk_i)
		float_q <= ~float_q;

	// device drive wins over the far side; pulls only act on a released pin
	always_comb
		for (int i = 0; i < 7; i++)
			if (pad_oe_i[i])
				pad_level_o[i] = pad_out_i[i];
			else if (ext_en_i[i])
				pad_level_o[i] = ext_val_i[i];
			else if (pullup_i[i])
				pad_level_o[i] = 1'b1;
			else if (pulldown_i[i])
				pad_level_o[i] = 1'b0;
			else
				pad_level_o[i] = float_q[i];
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the port d function and pad control block
`timescale 1ns/10ps
`default_nettype none
`include "pdfpc_defs.svh"

module testbench;
	logic        core_clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [6:0]  port_data_i = 7'h0, port_out_en_i = 7'h0, pin_input_enable_i = 7'h0;
	logic        stop_mode_i = 1'b0, standby_pin_drive_i = 1'b0;
	logic        serial2_transmit_i = 1'b0, serial2_clock_i = 1'b0;
	logic        serial2_clock_oe_i = 1'b0, timer5_output_i = 1'b0;
	logic [6:0]  pad_in_i, pad_out_o, pad_oe_o, pullup_o, pulldown_o, port_pin_value_o;
	logic [6:0]  ext_val = 7'h0, ext_en = 7'h0; // far-side drive
	logic [6:0]  pad_prev = 7'h0;               // pad levels the design sampled
	wire logic [7:0] periph;                    // peripheral inputs, receive down to timer
	logic [31:0] seed = 32'h1867;
	logic [31:0] x, y;
	logic [31:0] v [5];
	logic [13:0] pe;
	logic [7:0]  ofs [5] = '{`PDFPC_OFS_ALT_A, `PDFPC_OFS_ALT_B, `PDFPC_OFS_OPEN_DRAIN,
		`PDFPC_OFS_PULLUP, `PDFPC_OFS_PULLDOWN};
	logic [31:0] msk [5] = '{`PDFPC_MASK_ALT_A, `PDFPC_MASK_ALT_B, `PDFPC_MASK_PIN,
		`PDFPC_MASK_PIN, `PDFPC_MASK_PIN};
	int          fail_count = 0;
	int          num_checks = 0;

	pdfpc_top dut_u (.core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .port_data_i, .port_out_en_i, .pin_input_enable_i, .stop_mode_i,
		.standby_pin_drive_i, .pad_in_i, .pad_out_o, .pad_oe_o, .pullup_o, .pulldown_o,
		.serial2_transmit_i, .serial2_clock_i, .serial2_clock_oe_i, .timer5_output_i,
		.serial2_receive_o(periph[7]), .serial2_clock_in_o(periph[6]),
		.serial2_clear_to_send_o(periph[5]), .external_interrupt_nine_o(periph[4]),
		.encoder0_index_o(periph[3]), .encoder0_phase_b_o(periph[2]),
		.encoder0_phase_a_o(periph[1]), .timer5_input_o(periph[0]), .port_pin_value_o);

	pdfpc_pad_model pads_u (.core_clk_i(core_clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
		.pullup_i(pullup_o), .pulldown_i(pulldown_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
		.pad_level_o(pad_in_i));

	// 50 MHz clock
	always #10 core_clk_i = ~core_clk_i;

	// same edge sample as the design, so the feedback loop stays race free
	always @(posedge core_clk_i)
		pad_prev <= pad_in_i;

	// repeatable pseudo-random source
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// expected pad value and enable; input functions release the pad
	function automatic logic [13:0] exp_pad(input logic [6:0] a, b, od);
		logic [6:0] pv, en;
		for (int i = 0; i < 7; i++)
		begin
			pv[i] = port_data_i[i];
			en[i] = port_out_en_i[i];
			if (a[i] | b[i])
			begin
				pv[i] = (i == 5) ? serial2_transmit_i : (i == 4) ? serial2_clock_i : timer5_output_i;
				en[i] = a[i] ? (i == 5 || (i == 4 && serial2_clock_oe_i)) : (i == 1);
			end
			if (od[i])
			begin
				en[i] = en[i] & ~pv[i];
				pv[i] = 1'b0;
			end
			if (stop_mode_i & ~standby_pin_drive_i)
				en[i] = 1'b0;
		end
		return {pv, en};
	endfunction

	// expected peripheral inputs; interrupt ignores selection outside stop mode
	function automatic logic [7:0] exp_periph(input logic [6:0] a, b, p);
		logic [6:0] q;
		q = p & pin_input_enable_i;
		return {q[6] & a[6], q[4] & a[4], q[4] & b[4], stop_mode_i ? q[3] & a[3] : q[3],
			q[2] & a[2], q[1] & a[1], q[0] & a[0], q[0] & b[0]};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// read data stand one cycle only, then fall back to zero
	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o, exp);
		@(posedge core_clk_i);
		#1 check(reg_rdata_o, 32'h0);
	endtask

	// write then read back with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o, exp);
	endtask

	task automatic final_report;
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// reset, directed corners, random sweep, reset in mid-run
	initial
	begin
		repeat (20) @(posedge core_clk_i);
		srst_i <= 1'b0;
		#1 check(32'({pad_oe_o, pullup_o, pulldown_o, periph}), 32'h0);
		for (int k = 0; k < 5; k++)
			rd_check(ofs[k], `PDFPC_RESET_VALUE);
		wr(8'h10, 32'hffffffff);
		rd_check(8'h10, 32'h0);
		rd_check(8'h00, 32'h0);
		wr_rd(`PDFPC_OFS_ALT_A, 32'hffffffaa, 32'h0000002a);
		for (int n = 0; n < 40; n++)
		begin
			for (int k = 0; k < 5; k++)
				v[k] = (n == 0) ? 32'hffffffff : rnd();
			if (n == 1)
				v[0] = 32'h0;
			v[1] = v[1] & ~v[0];
			for (int k = 0; k < 5; k++)
				wr(ofs[k], v[k]);
			for (int k = 0; k < 5; k++)
				rd_check(ofs[k], v[k] & msk[k]);
			x = rnd();
			y = rnd();
			@(posedge core_clk_i);
			{standby_pin_drive_i, stop_mode_i, pin_input_enable_i, port_out_en_i, port_data_i} <= x[22:0];
			{timer5_output_i, serial2_clock_oe_i, serial2_clock_i, serial2_transmit_i} <= x[26:23];
			{ext_en, ext_val} <= y[13:0];
			repeat (2) @(posedge core_clk_i);
			#1 pe = exp_pad(v[0][6:0], v[1][6:0] & msk[1][6:0], v[2][6:0]);
			check(32'(pad_oe_o), 32'(pe[6:0]));
			check(32'(pad_out_o & (pe[6:0] | v[2][6:0])), 32'(pe[13:7] & pe[6:0]));
			check(32'(pullup_o), v[3] & msk[3]);
			check(32'(pulldown_o), v[4] & msk[4]);
			check(32'(periph), 32'(exp_periph(v[0][6:0], v[1][6:0] & msk[1][6:0], pad_prev)));
			check(32'(port_pin_value_o), 32'(pad_prev & pin_input_enable_i));
		end
		@(posedge core_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		srst_i <= 1'b0;
		#1 check(32'({pad_oe_o, pullup_o, pulldown_o}), 32'h0);
		for (int k = 0; k < 5; k++)
			rd_check(ofs[k], `PDFPC_RESET_VALUE);
		final_report();
	end
endmodule
`default_nettype wire
